/* File: dam_pkg.sv */
package dam_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int AMP_CLK_MAX_HZ = 250_000;
   localparam int SYNC_DIV = 8;
   localparam int ADC_DIV = (CLK_HZ + AMP_CLK_MAX_HZ * SYNC_DIV - 1) / (AMP_CLK_MAX_HZ * SYNC_DIV);
   localparam logic [5:0] ADC_DIV_LAST = 6'(ADC_DIV - 1);
   localparam logic [5:0] ADC_DIV_ZERO = 6'h0;
   localparam logic [2:0] OCT_LAST = 3'(SYNC_DIV - 1);
   localparam logic [3:0] CONV_TICKS_SHORT = 4'hD;
   localparam logic [3:0] CONV_TICKS_LONG = 4'hE;
   localparam logic [3:0] CONV_TICKS_SAMPLE = 4'h2;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [2:0] ADDR_AMP0 = 3'h0;
   localparam logic [2:0] ADDR_AMP1 = 3'h1;
   localparam logic [2:0] ADDR_CONV = 3'h2;
   localparam logic [2:0] ADDR_RES_HI = 3'h3;
   localparam logic [2:0] ADDR_RES_LO = 3'h4;
   localparam int BIT_ON = 7;
   localparam int BIT_SHORT = 6;
   localparam int BIT_GAIN_HI = 5;
   localparam int BIT_GAIN_LO = 4;
   localparam int BIT_TRIG_HI = 1;
   localparam int BIT_TRIG_LO = 0;
   localparam int BIT_START = 0;
   localparam int BIT_SEL = 1;
   localparam int BIT_AUTO = 2;
   localparam int BIT_BUSY = 3;
   localparam logic [1:0] UNUSED_BITS = 2'h0;
   localparam logic [3:0] CONV_PAD = 4'h0;
   localparam logic [5:0] RES_PAD = 6'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [9:0] RES_RESET = 10'h000;
   localparam logic [1:0] TRIG_DIV8 = 2'h0;
   localparam logic [1:0] TRIG_ONE = 2'h1;
   localparam logic [1:0] GAIN_X5 = 2'h0;
   localparam logic [1:0] GAIN_X10 = 2'h1;
   localparam logic [1:0] GAIN_X20 = 2'h2;
   localparam logic [1:0] GAIN_X40 = 2'h3;
   typedef logic [2:0] dam_addr_t;
   typedef logic [7:0] dam_byte_t;
   typedef logic [9:0] dam_sample_t;
   typedef struct packed {
      logic on;
      logic short_in;
      logic [1:0] gain;
      logic [1:0] trig;
   } dam_amp_s;
   localparam dam_amp_s AMP_RESET = '{on: 1'b0, short_in: 1'b0, gain: GAIN_X5, trig: TRIG_DIV8};
   typedef enum logic [1:0] {DAM_IDLE, DAM_WAIT, DAM_CONV} dam_state_e;
endpackage : dam_pkg

/* File: dam_amp_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - Bit 7 of each amplifier control register powers that amplifier up when one and down when zero.
// - Clearing an enable bit during a conversion on that amplifier takes effect only when the conversion ends.
// - Bit 6 shorts the amplifier's differential input when set and leaves normal operation when clear.
// - Gain bits 5:4 select gain 5, 10, 20 or 40 for codes 00, 01, 10 and 11.
// - Trigger bits 1:0 select the ADC clock divided by eight or the sync events of stages 0, 1 and 2.
// - A started divide-by-eight conversion proceeds at once; stage-triggered conversions and restarts wait for the selected trigger source.
// - Conversions start from the conversion control register and land in the high and low result registers.
// - Two independent amplifiers each have their own control register of identical layout with bits 3:2 unused.
// - With the divide-by-eight trigger the amplifier synchronization clock never runs faster than 250 kHz; stage sync events are not limited.
// - A divide-by-eight conversion takes 13 ADC clocks with the half-rate phase low and 14 with it high.
// - A change of amplifier output during the sample phase aborts the conversion and restarts it when stable.
// - Only stage sync sources auto-trigger, starting at the next amplifier clock event after the trigger.
module dam_amp_ctrl (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire dam_pkg::dam_addr_t reg_addr_i,
   input wire dam_pkg::dam_byte_t reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output dam_pkg::dam_byte_t reg_rdata_o,
   input wire logic [2:0] stage_sync_event_i,
   input wire logic [1:0] amp_out_change_i,
   input wire dam_pkg::dam_sample_t adc_sample_i,
   output dam_pkg::dam_amp_s amp_cfg_o [2],
   output logic [1:0] amp_clk_evt_o,
   output logic half_rate_phase_clock_o,
   output logic conv_sample_o,
   output logic conv_busy_o,
   output logic conv_amp_o
);
   import dam_pkg::*;

   function automatic dam_byte_t pack_ctrl(input dam_amp_s c);
      pack_ctrl = {c.on, c.short_in, c.gain, UNUSED_BITS, c.trig};
   endfunction : pack_ctrl

   function automatic dam_amp_s unpack_ctrl(input dam_byte_t b);
      dam_amp_s c;
      c.on = b[BIT_ON];
      c.short_in = b[BIT_SHORT];
      c.gain = {b[BIT_GAIN_HI], b[BIT_GAIN_LO]};
      c.trig = {b[BIT_TRIG_HI], b[BIT_TRIG_LO]};
      unpack_ctrl = c;
   endfunction : unpack_ctrl

   function automatic logic pick_event(input logic [1:0] trig, input logic oct, input logic [2:0] edges);
      logic evt;
      evt = oct;
      if (trig != TRIG_DIV8) begin
         evt = edges[trig - TRIG_ONE];
      end
      pick_event = evt;
   endfunction : pick_event

   dam_amp_s ctrl_q [2];
   dam_amp_s ctrl_d [2];
   logic start_q;
   logic start_d;
   logic sel_q;
   logic sel_d;
   logic auto_q;
   logic auto_d;
   dam_sample_t res_q;
   dam_sample_t res_d;
   dam_byte_t rdata_q;
   dam_byte_t rdata_d;

   logic [5:0] div_q;
   logic [5:0] div_d;
   logic phase_q;
   logic phase_d;
   logic [2:0] oct_q;
   logic [2:0] oct_d;
   logic tick;
   logic oct_evt;

   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] sync3_q;
   logic [2:0] stage_edge;

   dam_state_e state_q;
   dam_state_e state_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [3:0] len_q;
   logic [3:0] len_d;
   logic act_q;
   logic act_d;
   logic hold_q;
   logic hold_d;
   logic pend_q;
   logic pend_d;
   logic done;

   logic [1:0] eff_on;
   logic [1:0] amp_evt;
   dam_amp_s cfg_q [2];
   dam_amp_s cfg_d [2];
   logic [1:0] aclk_q;
   logic samp_q;
   logic samp_d;
   logic busy_q;
   logic busy_d;

   // The ADC clock is a tick from a divider sized so its eighth stays within the amplifier limit.
   always_comb begin
      tick = (div_q == ADC_DIV_LAST);
      div_d = tick ? ADC_DIV_ZERO : div_q + 6'h01;
      phase_d = tick ? ~phase_q : phase_q;
      oct_d = tick ? oct_q + 3'h1 : oct_q;
      oct_evt = tick && (oct_q == OCT_LAST);
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q <= ADC_DIV_ZERO;
         phase_q <= 1'b0;
         oct_q <= 3'h0;
      end else begin
         div_q <= div_d;
         phase_q <= phase_d;
         oct_q <= oct_d;
      end
   end

   // The first stage is read by the second stage only; edges come from the settled copies.
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         sync3_q <= 3'h0;
      end else begin
         sync1_q <= stage_sync_event_i;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   assign stage_edge = sync2_q & ~sync3_q;

   // An amplifier clocks only while it is powered, including the deferred-off window.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         eff_on[i] = ctrl_q[i].on || (hold_q && (act_q == 1'(i)));
         amp_evt[i] = eff_on[i] && pick_event(ctrl_q[i].trig, oct_evt, stage_edge);
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      len_d = len_q;
      act_d = act_q;
      hold_d = hold_q;
      pend_d = pend_q;
      done = 1'b0;
      unique case (state_q)
         DAM_IDLE: begin
            if (start_q || pend_q) begin
               pend_d = 1'b0;
               act_d = sel_q;
               hold_d = ctrl_q[sel_q].on;
               if (start_q && (ctrl_q[sel_q].trig == TRIG_DIV8)) begin
                  state_d = DAM_CONV;
                  cnt_d = CNT_ZERO;
                  len_d = phase_q ? CONV_TICKS_LONG : CONV_TICKS_SHORT;
               end else begin
                  state_d = DAM_WAIT;
               end
            end
         end
         DAM_WAIT: begin
            if (amp_evt[act_q]) begin
               state_d = DAM_CONV;
               cnt_d = CNT_ZERO;
               len_d = CONV_TICKS_SHORT;
            end
         end
         DAM_CONV: begin
            if ((cnt_q < CONV_TICKS_SAMPLE) && amp_out_change_i[act_q]) begin
               state_d = DAM_WAIT;
            end else if (tick) begin
               if (cnt_q == len_q - CNT_ONE) begin
                  done = 1'b1;
                  state_d = DAM_IDLE;
                  hold_d = 1'b0;
               end else begin
                  cnt_d = cnt_q + CNT_ONE;
               end
            end
         end
         default: begin
            state_d = DAM_IDLE;
         end
      endcase
      // A trigger edge in the cycle a pending start is taken is kept, so that trigger is not lost.
      if (auto_q && (ctrl_q[sel_q].trig != TRIG_DIV8) && stage_edge[ctrl_q[sel_q].trig - TRIG_ONE]) begin
         pend_d = 1'b1;
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= DAM_IDLE;
         cnt_q <= CNT_ZERO;
         len_q <= CONV_TICKS_SHORT;
         act_q <= 1'b0;
         hold_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         len_q <= len_d;
         act_q <= act_d;
         hold_q <= hold_d;
         pend_q <= pend_d;
      end
   end

   // The start bit clears at completion, but a write of one in that same cycle still wins.
   always_comb begin
      ctrl_d = ctrl_q;
      start_d = done ? 1'b0 : start_q;
      sel_d = sel_q;
      auto_d = auto_q;
      res_d = done ? adc_sample_i : res_q;
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            ADDR_AMP0: begin
               ctrl_d[0] = unpack_ctrl(reg_wdata_i);
            end
            ADDR_AMP1: begin
               ctrl_d[1] = unpack_ctrl(reg_wdata_i);
            end
            ADDR_CONV: begin
               sel_d = reg_wdata_i[BIT_SEL];
               auto_d = reg_wdata_i[BIT_AUTO];
               if (reg_wdata_i[BIT_START]) begin
                  start_d = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rdata_d = BYTE_ZERO;
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            ADDR_AMP0: rdata_d = pack_ctrl(ctrl_q[0]);
            ADDR_AMP1: rdata_d = pack_ctrl(ctrl_q[1]);
            ADDR_CONV: rdata_d = {CONV_PAD, busy_q, auto_q, sel_q, start_q};
            ADDR_RES_HI: rdata_d = {RES_PAD, res_q[9:8]};
            ADDR_RES_LO: rdata_d = res_q[7:0];
            default: rdata_d = BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_q[0] <= AMP_RESET;
         ctrl_q[1] <= AMP_RESET;
         start_q <= 1'b0;
         sel_q <= 1'b0;
         auto_q <= 1'b0;
         res_q <= RES_RESET;
         rdata_q <= BYTE_ZERO;
      end else begin
         ctrl_q <= ctrl_d;
         start_q <= start_d;
         sel_q <= sel_d;
         auto_q <= auto_d;
         res_q <= res_d;
         rdata_q <= rdata_d;
      end
   end

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cfg_d[i] = ctrl_q[i];
         cfg_d[i].on = eff_on[i];
      end
      samp_d = (state_q == DAM_CONV) && (cnt_q < CONV_TICKS_SAMPLE);
      busy_d = (state_d != DAM_IDLE);
   end

   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg_q[0] <= AMP_RESET;
         cfg_q[1] <= AMP_RESET;
         aclk_q <= 2'h0;
         samp_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         aclk_q <= amp_evt;
         samp_q <= samp_d;
         busy_q <= busy_d;
      end
   end

   assign reg_rdata_o = rdata_q;
   assign amp_cfg_o = cfg_q;
   assign amp_clk_evt_o = aclk_q;
   assign half_rate_phase_clock_o = phase_q;
   assign conv_sample_o = samp_q;
   assign conv_busy_o = busy_q;
   assign conv_amp_o = act_q;
endmodule : dam_amp_ctrl

/* File: dam_far_model.sv */
`timescale 1ns/1ps
module dam_far_model (
   input wire logic clock_i,
   output logic [2:0] sync_o,
   output logic [1:0] chg_o,
   output dam_pkg::dam_sample_t sample_o
);
   initial begin
      sync_o = 3'h0;
      chg_o = 2'h0;
      sample_o = 10'h2A5;
   end
   // Sync levels are held for four clocks so the two-flop resynchroniser cannot miss them.
   task automatic pulse(input int n);
      sync_o[n] <= 1'b1;
      repeat (4) @(posedge clock_i);
      sync_o[n] <= 1'b0;
   endtask : pulse
   task automatic upset(input int n);
      chg_o[n] <= 1'b1;
      repeat (20) @(posedge clock_i);
      chg_o[n] <= 1'b0;
   endtask : upset
endmodule : dam_far_model

/* File: dam_amp_ctrl_asserts.sv */
`timescale 1ns/1ps
module dam_chk (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire dam_pkg::dam_addr_t reg_addr_i,
   input wire dam_pkg::dam_byte_t reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire dam_pkg::dam_byte_t reg_rdata_o,
   input wire logic [2:0] stage_sync_event_i,
   input wire dam_pkg::dam_amp_s amp_cfg_o [2],
   input wire logic [1:0] amp_clk_evt_o,
   input wire logic conv_sample_o,
   input wire logic conv_busy_o,
   input wire logic conv_amp_o
);
   import dam_pkg::*;
   logic [9:0] len_q;
   logic [9:0] len_d;
   logic [9:0] gap_q;
   logic [9:0] gap_d;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   always_comb begin
      len_d = conv_busy_o ? len_q + 10'h001 : 10'h000;
      gap_d = amp_clk_evt_o[0] ? 10'h000 : ((gap_q == 10'h3FF) ? gap_q : gap_q + 10'h001);
   end
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         len_q <= 10'h000;
         gap_q <= 10'h3FF;
      end else begin
         len_q <= len_d;
         gap_q <= gap_d;
      end
   end
   property p_cfg;
      (reg_wr_i && reg_addr_i == ADDR_AMP1) |->
         ##2 {amp_cfg_o[1].short_in, amp_cfg_o[1].gain, amp_cfg_o[1].trig} ==
         {$past(reg_wdata_i[6:4], 2), $past(reg_wdata_i[1:0], 2)};
   endproperty
   a_cfg_copy: assert property (p_cfg) else $error("amp one config mismatch");
   a_on_write: assert property (reg_wr_i && reg_addr_i == ADDR_AMP0 && reg_wdata_i[BIT_ON] |->
      ##2 amp_cfg_o[0].on) else $error("amp zero not on");
   a_read_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == BYTE_ZERO)
      else $error("read data not zero");
   a_unused_zero: assert property (reg_rd_i && reg_addr_i <= ADDR_AMP1 |=> reg_rdata_o[3:2] == UNUSED_BITS)
      else $error("unused bits set");
   a_hi_pad: assert property (reg_rd_i && reg_addr_i == ADDR_RES_HI |=> reg_rdata_o[7:2] == RES_PAD)
      else $error("result high padding set");
   a_defer_off: assert property (conv_busy_o && !conv_amp_o && amp_cfg_o[0].on |->
      ##2 (amp_cfg_o[0].on || !conv_busy_o)) else $error("amp zero off during conversion");
   a_sample_busy: assert property (conv_sample_o |-> conv_busy_o) else $error("sample while idle");
   a_reset_clean: assert property ($fell(sys_rst_i) |-> !conv_busy_o && amp_cfg_o[0] == AMP_RESET &&
      amp_cfg_o[1] == AMP_RESET) else $error("state not clear after reset");
   a_stage_evt: assert property ($rose(stage_sync_event_i[0]) && amp_cfg_o[1].on &&
      amp_cfg_o[1].trig == TRIG_ONE |-> ##[1:5] amp_clk_evt_o[1]) else $error("stage event lost");
   a_div8_len: assert property ($fell(conv_busy_o) && amp_cfg_o[conv_amp_o].trig == TRIG_DIV8 |->
      len_q inside {[10'h259:10'h2BC]}) else $error("conversion length wrong");
   a_div8_rate: assert property (amp_clk_evt_o[0] && amp_cfg_o[0].trig == TRIG_DIV8 |->
      gap_q >= 10'h18F) else $error("amp zero sync clock too fast");
   c_done: cover property ($fell(conv_busy_o));
   c_stage: cover property (amp_clk_evt_o[1]);
   c_sample: cover property ($rose(conv_sample_o));
endmodule : dam_chk
bind dam_amp_ctrl dam_chk CHK (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .stage_sync_event_i(stage_sync_event_i), .amp_cfg_o(amp_cfg_o), .amp_clk_evt_o(amp_clk_evt_o),
   .conv_sample_o(conv_sample_o), .conv_busy_o(conv_busy_o), .conv_amp_o(conv_amp_o));

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import dam_pkg::*;
   logic clock_i;
   logic sys_rst_i;
   dam_addr_t reg_addr_i;
   dam_byte_t reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   dam_byte_t reg_rdata_o;
   logic [2:0] sync;
   logic [1:0] chg;
   dam_sample_t sample;
   dam_amp_s amp_cfg_o [2];
   logic conv_sample_o;
   logic conv_busy_o;
   logic phase;
   logic phase_mark;
   int fail_count = 0;
   int checked = 0;
   dam_amp_ctrl DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .stage_sync_event_i(sync), .amp_out_change_i(chg), .adc_sample_i(sample), .amp_cfg_o(amp_cfg_o),
      .amp_clk_evt_o(), .half_rate_phase_clock_o(phase), .conv_sample_o(conv_sample_o),
      .conv_busy_o(conv_busy_o), .conv_amp_o());
   dam_far_model FAR (.clock_i(clock_i), .sync_o(sync), .chg_o(chg), .sample_o(sample));
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   task automatic conclude();
      $display("Checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // The delay follows the call, so values are those seen when chk is called; rdchk and idle wait 1 ns before calling.
   task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
      #1;
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input dam_addr_t a, input dam_byte_t d);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
   task automatic rdchk(input dam_addr_t a, input dam_byte_t e, input string n);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(n, 10'(e), 10'(reg_rdata_o));
   endtask : rdchk
   task automatic idle();
      int n = 0;
      while (conv_busy_o !== 1'b0 && n < 3000) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      chk("busy", 10'h000, 10'(conv_busy_o));
   endtask : idle
   initial begin
      repeat (20000) @(posedge clock_i);
      fail_count++;
      conclude();
   end
   initial begin
      sys_rst_i = 1'b1;
      reg_addr_i = 3'h0;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      repeat (8) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      rdchk(ADDR_AMP0, 8'h00, "amp0 reset");
      rdchk(ADDR_AMP1, 8'h00, "amp1 reset");
      phase_mark = phase;
      repeat (ADC_DIV) @(posedge clock_i);
      chk("phase", 10'(!phase_mark), 10'(phase));
      wr(3'h5, 8'hFF);
      rdchk(3'h5, 8'h00, "unmapped");
      for (int g = 0; g < 4; g++) begin
         wr(ADDR_AMP1, 8'h4C | 8'(g << 4));
         rdchk(ADDR_AMP1, 8'h40 | 8'(g << 4), "amp1 cfg");
         chk("amp1 gain", 10'(g), 10'(amp_cfg_o[1].gain));
      end
      wr(ADDR_AMP0, 8'h80);
      wr(ADDR_CONV, 8'h01);
      repeat (2) @(posedge clock_i);
      chk("busy", 10'h001, 10'(conv_busy_o));
      wr(ADDR_AMP0, 8'h00);
      repeat (3) @(posedge clock_i);
      chk("amp0 held", 10'h001, 10'(amp_cfg_o[0].on));
      rdchk(ADDR_CONV, 8'h09, "conv status");
      idle();
      repeat (2) @(posedge clock_i);
      chk("amp0 off", 10'h000, 10'(amp_cfg_o[0].on));
      rdchk(ADDR_CONV, 8'h00, "conv done");
      rdchk(ADDR_RES_HI, 8'h02, "result high");
      rdchk(ADDR_RES_LO, 8'hA5, "result low");
      wr(ADDR_AMP1, 8'h81);
      wr(ADDR_CONV, 8'h03);
      repeat (900) @(posedge clock_i);
      chk("untriggered sample", 10'h000, 10'(conv_sample_o));
      FAR.pulse(0);
      FAR.upset(1);
      repeat (800) @(posedge clock_i);
      chk("aborted busy", 10'h001, 10'(conv_busy_o));
      FAR.pulse(0);
      idle();
      rdchk(ADDR_RES_LO, 8'hA5, "result low");
      wr(ADDR_CONV, 8'h06);
      FAR.pulse(0);
      repeat (2) @(posedge clock_i);
      chk("auto pending", 10'h001, 10'(conv_busy_o));
      chk("auto wait", 10'h000, 10'(conv_sample_o));
      wr(ADDR_CONV, 8'h02);
      FAR.pulse(0);
      idle();
      rdchk(ADDR_CONV, 8'h02, "auto done");
      conclude();
   end
endmodule : tb_top
